// ---- common/tap_pkg.sv ----
package tap_pkg;

  // instruction register geometry and codes, msb on the left
  localparam int         IR_W       = 3;
  localparam logic [2:0] OP_EXTEST  = 3'h0;
  localparam logic [2:0] OP_IDCODE  = 3'h1;
  localparam logic [2:0] OP_SAMPLEZ = 3'h2;
  localparam logic [2:0] OP_RSV_A   = 3'h3;
  localparam logic [2:0] OP_SAMPLE  = 3'h4;
  localparam logic [2:0] OP_PRIVATE = 3'h5;
  localparam logic [2:0] OP_RSV_B   = 3'h6;
  localparam logic [2:0] OP_BYPASS  = 3'h7;

  // values loaded at capture and at reset
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic [2:0] IR_RESET   = OP_IDCODE;
  localparam int         ID_W       = 32;
  localparam logic       FILL_VAL   = 1'h1;
  localparam logic       BYP_CAP    = 1'h0;

  // sixteen-state test access controller
  typedef enum logic [3:0] {
    S_RESET    = 4'h0,
    S_IDLE     = 4'h1,
    S_DR_SEL   = 4'h2,
    S_DR_CAP   = 4'h3,
    S_DR_SHIFT = 4'h4,
    S_DR_EX1   = 4'h5,
    S_DR_PAUSE = 4'h6,
    S_DR_EX2   = 4'h7,
    S_DR_UPD   = 4'h8,
    S_IR_SEL   = 4'h9,
    S_IR_CAP   = 4'ha,
    S_IR_SHIFT = 4'hb,
    S_IR_EX1   = 4'hc,
    S_IR_PAUSE = 4'hd,
    S_IR_EX2   = 4'he,
    S_IR_UPD   = 4'hf
  } tap_state_t;

endpackage : tap_pkg

// ---- design/bit_sync.sv ----
`timescale 1ns/10ps
module bit_sync #(
  parameter int W = 1
) (
  // destination clock
  input  wire logic         clk,
  // asynchronous source and synchronised result
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // two flops; the first is read only by the second
  always_ff @(posedge clk) begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule : bit_sync

// ---- design/tap_port.sv ----
// Behaviour
// (RULE_01) identification register is 32 bits, loaded with a fixed code at capture
// (RULE_02) code comes from a constant store and shifts out bit zero first
// (RULE_03) instruction capture loads the two low bits with 01
// (RULE_04) instruction shift moves tdi in while old contents leave on tdo
// (RULE_05) new instruction takes effect only at instruction update
// (RULE_06) code 111 puts the bypass flop in the scan path
// (RULE_07) code 100 captures pin states and shifts the boundary register
// (RULE_08) cells without a pin capture a fixed default value
// (RULE_09) far side keeps ram inputs stable around the capturing edge
// (RULE_10) code 000 is external test, boundary register in the path
// (RULE_11) external test never blocks the functional input pins
// (RULE_12) external test drives the update stage onto outputs from the falling edge; here outputs change on a later mclk rising edge through hold_r
// (RULE_13) external test capture loads all pins plus defaults; outputs keep driving
// (RULE_14) identification code 001 is loaded at power-up and in reset state
// (RULE_15) code 010 floats ram outputs except echo clock, boundary register in path
// (RULE_16) reserved codes 011 and 110 act exactly as bypass
// (RULE_17) instruction register is three bits, msb on the left
// (RULE_18) five rising edges with tms high reach the reset state
// (RULE_19) tms and tdi sampled on rising edge, tdo changes on falling, driven in shift
// (RULE_20) bypass register is one flop, one stage of delay
// (RULE_21) private code 101 behaves like bypass
// (RULE_22) controller is the standard sixteen-state machine stepped by tms
`timescale 1ns/10ps
module tap_port #(
  parameter int          NI      = 8,
  parameter int          NIO     = 8,
  parameter int          NP      = 2,
  parameter logic [31:0] ID_CODE = 32'h1234_5001  // arbitrary value, bit zero set
) (
  // ram clock domain
  input  wire logic           mclk,
  input  wire logic           rst_n,
  // test link
  input  wire logic           tck,
  input  wire logic           tms,
  input  wire logic           tdi,
  output logic                tdo,
  output logic                tdo_oe,
  // ram pins
  input  wire logic [NI-1:0]  pin_in,
  input  wire logic [NIO-1:0] io_in,
  output logic      [NIO-1:0] io_out,
  output logic                io_oe,
  output logic                echo_clock_out,
  // ram core drive
  input  wire logic [NIO-1:0] core_dq,
  input  wire logic           core_dq_oe,
  input  wire logic           core_echo
);

  localparam int PW = NI + NIO + 1;
  localparam int BW = PW + NP;

  tap_pkg::tap_state_t state_r;
  tap_pkg::tap_state_t state_nxt;
  logic                rst_t_n;
  logic [2:0]          ir_sr_r;
  logic [2:0]          ir_r;
  logic [2:0]          ir_nxt;
  logic [31:0]         id_sr_r;
  logic                byp_r;
  logic [BW-1:0]       bsr_sr_r;
  logic [BW-1:0]       bsr_upd_r;
  logic [BW-1:0]       xfer_r;
  logic [BW-1:0]       hold_r;
  logic [PW-1:0]       pins_t;
  logic                mode_ext_r;
  logic                mode_flt_r;
  logic                req_r;
  logic                pend_r;
  logic                ack_t;
  logic                ack_r;
  logic                ext_m;
  logic                flt_m;
  logic                req_m;
  logic                tdo_r;
  logic                tdo_oe_r;
  logic [NIO-1:0]      io_out_r;
  logic                io_oe_r;
  logic                echo_r;

  // power-up reset carried into the link domain
  bit_sync #(.W(1)) u_rst_sync (
    .clk (tck),
    .d   (rst_n),
    .q   (rst_t_n)
  );

  // pin levels sampled into the link domain; echo output seen as driven
  bit_sync #(.W(PW)) u_pin_sync (
    .clk (tck),
    .d   ({echo_r, io_in, pin_in}),
    .q   (pins_t)
  );

  // handshake acknowledge back into the link domain
  bit_sync #(.W(1)) u_ack_sync (
    .clk (tck),
    .d   (ack_r),
    .q   (ack_t)
  );

  // mode levels and transfer request into the ram domain
  bit_sync #(.W(3)) u_mode_sync (
    .clk (mclk),
    .d   ({req_r, mode_flt_r, mode_ext_r}),
    .q   ({req_m, flt_m, ext_m})
  );

  // controller next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tap_pkg::S_RESET:    state_nxt = tms ? tap_pkg::S_RESET  : tap_pkg::S_IDLE;
      tap_pkg::S_IDLE:     state_nxt = tms ? tap_pkg::S_DR_SEL : tap_pkg::S_IDLE;
      tap_pkg::S_DR_SEL:   state_nxt = tms ? tap_pkg::S_IR_SEL : tap_pkg::S_DR_CAP;
      tap_pkg::S_DR_CAP:   state_nxt = tms ? tap_pkg::S_DR_EX1 : tap_pkg::S_DR_SHIFT;
      tap_pkg::S_DR_SHIFT: state_nxt = tms ? tap_pkg::S_DR_EX1 : tap_pkg::S_DR_SHIFT;
      tap_pkg::S_DR_EX1:   state_nxt = tms ? tap_pkg::S_DR_UPD : tap_pkg::S_DR_PAUSE;
      tap_pkg::S_DR_PAUSE: state_nxt = tms ? tap_pkg::S_DR_EX2 : tap_pkg::S_DR_PAUSE;
      tap_pkg::S_DR_EX2:   state_nxt = tms ? tap_pkg::S_DR_UPD : tap_pkg::S_DR_SHIFT;
      tap_pkg::S_DR_UPD:   state_nxt = tms ? tap_pkg::S_DR_SEL : tap_pkg::S_IDLE;
      tap_pkg::S_IR_SEL:   state_nxt = tms ? tap_pkg::S_RESET  : tap_pkg::S_IR_CAP;
      tap_pkg::S_IR_CAP:   state_nxt = tms ? tap_pkg::S_IR_EX1 : tap_pkg::S_IR_SHIFT;
      tap_pkg::S_IR_SHIFT: state_nxt = tms ? tap_pkg::S_IR_EX1 : tap_pkg::S_IR_SHIFT;
      tap_pkg::S_IR_EX1:   state_nxt = tms ? tap_pkg::S_IR_UPD : tap_pkg::S_IR_PAUSE;
      tap_pkg::S_IR_PAUSE: state_nxt = tms ? tap_pkg::S_IR_EX2 : tap_pkg::S_IR_PAUSE;
      tap_pkg::S_IR_EX2:   state_nxt = tms ? tap_pkg::S_IR_UPD : tap_pkg::S_IR_SHIFT;
      tap_pkg::S_IR_UPD:   state_nxt = tms ? tap_pkg::S_DR_SEL : tap_pkg::S_IDLE;
      default:             state_nxt = tap_pkg::S_RESET;
    endcase
  end

  // controller steps on every rising tck edge
  always_ff @(posedge tck) begin
    if (!rst_t_n) begin
      state_r <= tap_pkg::S_RESET;
    end else begin
      state_r <= state_nxt;  // see RULE_22 see RULE_18 see RULE_19
    end
  end

  // state decodes
  wire st_ir_cap   = (state_r == tap_pkg::S_IR_CAP);
  wire st_ir_shift = (state_r == tap_pkg::S_IR_SHIFT);
  wire st_ir_upd   = (state_r == tap_pkg::S_IR_UPD);
  wire st_dr_cap   = (state_r == tap_pkg::S_DR_CAP);
  wire st_dr_shift = (state_r == tap_pkg::S_DR_SHIFT);
  wire st_dr_upd   = (state_r == tap_pkg::S_DR_UPD);
  wire st_reset    = (state_r == tap_pkg::S_RESET);
  wire st_shift    = st_ir_shift | st_dr_shift;

  // instruction decodes; every code not named below falls to bypass
  wire sel_id  = (ir_r == tap_pkg::OP_IDCODE);
  wire sel_bsr = (ir_r == tap_pkg::OP_EXTEST) | (ir_r == tap_pkg::OP_SAMPLEZ)
               | (ir_r == tap_pkg::OP_SAMPLE);  // see RULE_07 see RULE_10 see RULE_15
  wire sel_byp = ~sel_id & ~sel_bsr;  // see RULE_06 see RULE_16 see RULE_21

  // instruction shift stage
  always_ff @(posedge tck) begin
    if (!rst_t_n) begin
      ir_sr_r <= tap_pkg::IR_CAPTURE;
    end else if (st_ir_cap) begin
      ir_sr_r <= tap_pkg::IR_CAPTURE;  // see RULE_03
    end else if (st_ir_shift) begin
      ir_sr_r <= {tdi, ir_sr_r[2:1]};  // see RULE_04 see RULE_17
    end
  end

  // active instruction changes only at update or in reset state
  assign ir_nxt = (!rst_t_n || st_reset) ? tap_pkg::IR_RESET :  // see RULE_14
                  st_ir_upd ? ir_sr_r : ir_r;                   // see RULE_05

  // instruction and mode flags settle on the falling edge
  always_ff @(negedge tck) begin
    ir_r       <= ir_nxt;
    mode_ext_r <= (ir_nxt == tap_pkg::OP_EXTEST);   // see RULE_12
    mode_flt_r <= (ir_nxt == tap_pkg::OP_SAMPLEZ);  // see RULE_15
  end

  // identification register
  always_ff @(posedge tck) begin
    if (st_dr_cap && sel_id) begin
      id_sr_r <= ID_CODE;  // see RULE_01
    end else if (st_dr_shift && sel_id) begin
      id_sr_r <= {tdi, id_sr_r[31:1]};  // see RULE_02
    end
  end

  // single-stage bypass
  always_ff @(posedge tck) begin
    if (st_dr_cap) begin
      byp_r <= tap_pkg::BYP_CAP;
    end else if (st_dr_shift && sel_byp) begin
      byp_r <= tdi;  // see RULE_20
    end
  end

  // boundary register: pins, echo cell, then fixed cells on top
  // input pins are only observed here, never gated toward the core
  always_ff @(posedge tck) begin
    if (st_dr_cap && sel_bsr) begin
      bsr_sr_r <= {{NP{tap_pkg::FILL_VAL}}, pins_t};  // see RULE_08 see RULE_13 see RULE_11
    end else if (st_dr_shift && sel_bsr) begin
      bsr_sr_r <= {tdi, bsr_sr_r[BW-1:1]};  // see RULE_07
    end
  end

  // serial output select
  wire dr_lsb  = sel_id ? id_sr_r[0] : (sel_bsr ? bsr_sr_r[0] : byp_r);
  wire tdo_nxt = st_ir_shift ? ir_sr_r[0] : dr_lsb;
  wire upd_now = st_dr_upd & sel_bsr;
  wire idle_t  = (req_r == ack_t);

  // tdo changes on falling edge and is enabled only while shifting
  always_ff @(negedge tck) begin
    if (!rst_t_n) begin
      tdo_r    <= 1'h0;
      tdo_oe_r <= 1'h0;
    end else begin
      tdo_r    <= st_shift ? tdo_nxt : 1'h0;  // see RULE_19
      tdo_oe_r <= st_shift;
    end
  end

  // update stage and handshake toward the ram domain
  always_ff @(negedge tck) begin
    if (!rst_t_n) begin
      bsr_upd_r <= '0;
      xfer_r    <= '0;
      req_r     <= 1'h0;
      pend_r    <= 1'h0;
    end else begin
      if (upd_now) begin
        bsr_upd_r <= bsr_sr_r;
      end
      if (idle_t && pend_r) begin
        xfer_r <= bsr_upd_r;
        req_r  <= ~req_r;
      end
      pend_r <= upd_now | (pend_r & ~idle_t);  // new update wins over send
    end
  end

  // ram domain takes the word when a request arrives
  wire new_word = (req_m != ack_r);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_r  <= 1'h0;
      hold_r <= '0;
    end else begin
      ack_r <= req_m;
      if (new_word) begin
        hold_r <= xfer_r;
      end
    end
  end

  // output pin selection; external test drives the held update stage
  wire [NIO-1:0] io_out_nxt = ext_m ? hold_r[NI+NIO-1:NI] : core_dq;  // see RULE_12
  wire           io_oe_nxt  = ext_m | (~flt_m & core_dq_oe);          // see RULE_15
  wire           echo_nxt   = ext_m ? hold_r[NI+NIO] : core_echo;

  // pin output flops
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_out_r <= '0;
      io_oe_r  <= 1'h0;
      echo_r   <= 1'h0;
    end else begin
      io_out_r <= io_out_nxt;
      io_oe_r  <= io_oe_nxt;
      echo_r   <= echo_nxt;
    end
  end

  assign tdo            = tdo_r;
  assign tdo_oe         = tdo_oe_r;
  assign io_out         = io_out_r;
  assign io_oe          = io_oe_r;
  assign echo_clock_out = echo_r;

  // checks in the link domain
  sequence five_tms_high;
    tms [*5];
  endsequence

  sequence id_capture;
    st_dr_cap && sel_id;
  endsequence

  AST_IR_CAPTURE: assert property (  // see RULE_03
    @(posedge tck) disable iff (!rst_t_n)
    st_ir_cap |=> ir_sr_r[1:0] == 2'h1
  ) else $error("instruction capture pattern wrong");

  AST_IR_SHIFT: assert property (  // see RULE_04
    @(posedge tck) disable iff (!rst_t_n)
    st_ir_shift |=> ir_sr_r == {$past(tdi), $past(ir_sr_r[2:1])}
  ) else $error("instruction shift wrong");

  AST_IR_HOLD: assert property (  // see RULE_05
    @(posedge tck) disable iff (!rst_t_n)
    $changed(ir_r) |-> (st_ir_upd || st_reset)
  ) else $error("instruction changed outside update");

  AST_RESET_IDCODE: assert property (  // see RULE_14
    @(posedge tck) disable iff (!rst_t_n)
    st_reset |=> ir_r == tap_pkg::OP_IDCODE
  ) else $error("reset state did not select identification");

  AST_FIVE_ONES: assert property (  // see RULE_18
    @(posedge tck) disable iff (!rst_t_n)
    five_tms_high |=> st_reset
  ) else $error("five tms ones did not reach reset state");

  AST_ID_LOAD: assert property (  // see RULE_01
    @(posedge tck) disable iff (!rst_t_n)
    id_capture ##1 st_dr_shift |-> id_sr_r == ID_CODE && tdo_r == ID_CODE[0]
  ) else $error("identification load or first bit wrong");

  AST_BYPASS_DELAY: assert property (  // see RULE_20
    @(posedge tck) disable iff (!rst_t_n)
    (st_dr_shift && sel_byp) ##1 st_dr_shift |-> tdo_r == $past(tdi)
  ) else $error("bypass delay wrong");

  AST_TDO_ENABLE: assert property (  // see RULE_19
    @(posedge tck) disable iff (!rst_t_n)
    tdo_oe_r |-> st_shift
  ) else $error("tdo driven outside shift");

  AST_BSR_CAPTURE: assert property (  // see RULE_08
    @(posedge tck) disable iff (!rst_t_n)
    (st_dr_cap && sel_bsr) |=> bsr_sr_r[BW-1:PW] == {NP{tap_pkg::FILL_VAL}}
      && bsr_sr_r[PW-1:0] == $past(pins_t)
  ) else $error("boundary capture wrong");

  // checks in the ram domain
  AST_FLOAT_HIZ: assert property (  // see RULE_15
    @(posedge mclk) disable iff (!rst_n)
    (flt_m && !ext_m) |=> !io_oe_r && echo_r == $past(core_echo)
  ) else $error("float mode did not release outputs");

  AST_EXTEST_DRIVE: assert property (  // see RULE_12
    @(posedge mclk) disable iff (!rst_n)
    ext_m |=> io_oe_r && io_out_r == $past(hold_r[NI+NIO-1:NI])
  ) else $error("external test did not drive outputs");

endmodule : tap_port

// ---- testbench/jtag_ctl.sv ----
`timescale 1ns/10ps
module jtag_ctl (
  // test link toward the port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // lines start at their pull-up level, clock stands low between frames
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  // one link cycle: drive while low, sample {tdo_oe, tdo} just before the rise
  task automatic cyc(input logic m, input logic d, output logic [1:0] q);
    tms = m;
    tdi = d;
    #16;
    q   = {tdo_oe, tdo};
    tck = 1'h1;
    #16;
    tck = 1'h0;  // tms and tdi hold until the next cycle drives them
  endtask : cyc

  // free-running cycles with tms high, walks the controller into reset
  task automatic idle(input int n);
    logic [1:0] q;
    for (int i = 0; i < n; i++) begin
      cyc(1'h1, 1'h1, q);
    end
  endtask : idle
endmodule : jtag_ctl

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
  localparam int          BW  = 19;
  localparam logic [31:0] IDV = 32'h5a3c_0f01;  // arbitrary value, bit zero set
  localparam logic [31:0] PRE = 32'h0_6900;     // io drive 69, echo cell 0

  // design stimulus and observation
  logic        mclk, rst_n, tck, tms, tdi, tdo, tdo_oe;
  logic        io_oe, echo_clock_out, core_dq_oe, core_echo;
  logic [7:0]  pin_in, io_in, io_ext, io_out, core_dq;
  logic [1:0]  tq;
  logic [2:0]  cap;
  logic [31:0] got;
  int          errors, n_checks, cycles;
  logic [2:0]  codes [4] = '{3'h3, 3'h5, 3'h6, 3'h7};

  // io pad level seen by both parties
  assign io_in = io_oe ? io_out : io_ext;

  tap_port #(.NI(8), .NIO(8), .NP(2), .ID_CODE(IDV)) tap_port_i (
    .mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_in(pin_in), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .echo_clock_out(echo_clock_out), .core_dq(core_dq), .core_dq_oe(core_dq_oe),
    .core_echo(core_echo)
  );

  jtag_ctl jtag_ctl_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  // ram clock and hang guard
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report;
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask : w

  task automatic t(input logic m, input logic d);
    jtag_ctl_i.cyc(m, d, tq);
  endtask : t

  // idle -> shift-ir, shift code lsb first, optional pause, update, idle
  task automatic ir_load(input logic [2:0] c, input logic hold, output logic [2:0] cq);
    for (int i = 0; i < 4; i++) begin
      t(i < 2, 1'h1);
    end
    for (int i = 0; i < 3; i++) begin
      t(i == 2, c[i]);
      cq[i] = tq[0];
    end
    if (hold) begin
      t(1'h0, 1'h1);
      w(10);
      chk(32'(io_oe), 32'h0);
      t(1'h1, 1'h1);
    end
    t(1'h1, 1'h1);
    t(1'h0, 1'h1);
  endtask : ir_load

  // idle -> capture -> shift n bits lsb first -> update -> idle
  task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic [31:0] oe;
    dout = 32'h0;
    oe   = 32'h0;
    t(1'h1, 1'h1);
    chk(32'(tq), 32'h0);
    t(1'h0, 1'h1);
    t(1'h0, 1'h1);
    for (int i = 0; i < n; i++) begin
      t(i == n - 1, din[i]);
      dout[i] = tq[0];
      oe[i]   = tq[1];
    end
    t(1'h1, 1'h1);
    t(1'h0, 1'h1);
    chk(oe, 32'hffff_ffff >> (32 - n));
  endtask : dr

  // main sequence
  initial begin
    mclk       = 1'h0;
    rst_n      = 1'h0;
    pin_in     = 8'ha5;
    io_ext     = 8'h3c;
    core_dq    = 8'h96;
    core_dq_oe = 1'h0;
    core_echo  = 1'h1;
    errors     = 0;
    n_checks   = 0;
    cycles     = 0;
    fork
      begin
        w(10);
        rst_n = 1'h1;
      end
      jtag_ctl_i.idle(40);
    join
    t(1'h0, 1'h1);
    w(3);
    chk(32'(io_out), 32'(core_dq));
    chk(32'(io_oe), 32'(core_dq_oe));
    dr(32, 32'h0, got);
    chk(got, IDV);
    foreach (codes[k]) begin
      ir_load(codes[k], 1'h0, cap);
      chk(32'(cap), 32'h1);
      dr(4, 32'hb, got);
      chk(got, 32'h6);
    end
    // from shift-dr exactly five tms ones are needed to reach reset
    t(1'h1, 1'h1);
    t(1'h0, 1'h1);
    t(1'h0, 1'h1);
    jtag_ctl_i.idle(5);
    t(1'h0, 1'h1);
    dr(32, 32'h0, got);
    chk(got, IDV);
    ir_load(3'h4, 1'h0, cap);
    dr(BW, PRE, got);
    chk(got, 32'h7_3ca5);
    ir_load(3'h0, 1'h1, cap);
    w(10);
    chk(32'(io_oe), 32'h1);
    chk(32'(io_out), 32'h69);
    chk(32'(echo_clock_out), 32'h0);
    @(negedge mclk);
    pin_in = 8'h5a;
    io_ext = 8'hc3;
    w(4);
    dr(BW, 32'h1_a500, got);  // new drive a5, echo cell 1
    chk(got, 32'h6_695a);
    w(10);
    chk(32'(io_out), 32'ha5);
    chk(32'(echo_clock_out), 32'h1);
    // core wants to drive, so float mode must hold the pins released
    core_dq_oe = 1'h1;
    ir_load(3'h2, 1'h0, cap);
    w(10);
    chk(32'(io_oe), 32'h0);
    chk(32'(echo_clock_out), 32'h1);
    core_echo = 1'h0;
    w(3);
    chk(32'(echo_clock_out), 32'h0);
    dr(BW, PRE, got);
    chk(got, 32'h6_c35a);
    final_report();
  end
endmodule : tb
